// >>> verilog/host_link_watchdog.v
// Host link watchdog with safe-state output forcing and channel address lookup.
//
// Functional notes
// - Watchdog supervises host queries, off unless enabled.
// - Count 100 ms ticks; timeout forces safe outputs.
// - Timeout resets to 50 ticks, five seconds.
// - Safe state holds until host explicitly restores.
// - One digital safe mode per module: hold/on/off.
// - Addresses follow slot order and module type.
// - Map identical for every host link variant.
// - Every channel has word and coil address.
// - Word channels consecutive; bit address is word*16.
// - Bit channels share one word, bit=channel.
`timescale 1ns/1ps
`default_nettype none
`include "host_link_watchdog_regs.vh"

module host_link_watchdog (
  input  wire                               clk,           // 100 MHz clock.
  input  wire                               reset,         // Asynchronous, active high.
  input  wire                               wdg_enable,    // Watchdog switched on.
  input  wire                               query_valid,   // Pulse: addressed valid query.
  input  wire                               cfg_reset,     // Pulse: restore defaults.
  input  wire                               timeout_wr,    // Pulse: load new timeout.
  input  wire [15:0]                        timeout_in,    // New timeout in ticks.
  input  wire                               resume,        // Pulse: host restores outputs.
  input  wire [15:0]                        do_normal,     // Host digital outputs.
  input  wire [31:0]                        do_safe_mode,  // 2 bits per digital module.
  input  wire [31:0]                        ao_normal,     // Two 16-bit analog outputs.
  input  wire [3:0]                         ao_safe_mode,  // 2 bits per analog channel.
  input  wire [31:0]                        ao_safe_val,   // Configured safe values.
  input  wire [31:0]                        ao_low_lim,    // Low limits.
  input  wire [31:0]                        ao_high_lim,   // High limits.
  input  wire [2*`MAP_SLOTS-1:0]            slot_type,     // Installed module types.
  input  wire [`MAP_CH_BITS*`MAP_SLOTS-1:0] slot_chans,    // Channel count minus one.
  input  wire [`MAP_SLOT_BITS-1:0]          q_slot,        // Lookup slot.
  input  wire [`MAP_CH_BITS-1:0]            q_chan,        // Lookup channel.
  output reg  [15:0]                        do_out,        // Digital outputs.
  output reg  [31:0]                        ao_out,        // Analog outputs.
  output reg                                safe_active,   // Outputs forced safe.
  output reg  [15:0]                        timeout_q,     // Programmed timeout.
  output reg  [15:0]                        elapsed_q,     // Ticks since last query.
  output reg  [`MAP_ADDR_BITS-1:0]          word_addr_q,   // Looked-up register address.
  output reg  [`MAP_ADDR_BITS-1:0]          bit_addr_q,    // Looked-up coil address.
  output reg  [`MAP_ADDR_BITS-1:0]          data_len_q,    // Looked-up length.
  output reg  [3:0]                         bit_pos_q,     // Bit within word.
  output reg                                hit_q          // Lookup found a channel.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Tick prescaler.

  // A tick is ten million cycles at 100 MHz, so a real timeout takes that many
  // cycles per unit; short checks rely on a zero timeout instead.
  localparam [23:0] TICK_LAST = `WDG_TICK_LAST;        // Last count of a tick.
  reg  [23:0] presc_q;                                 // Cycle counter within a tick.
  wire        tick = (presc_q == TICK_LAST);           // One-cycle tick pulse.

  // The prescaler restarts with each query so a tick is a full 100 ms after it.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      presc_q <= 24'h000000;
    end else if (query_valid || !wdg_enable || tick) begin
      presc_q <= 24'h000000;
    end else begin
      presc_q <= presc_q + 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timeout setting.

  // Default of 50 ticks comes back on reset and on a configuration reset.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      timeout_q <= `WDG_TIMEOUT_RST;
    end else if (cfg_reset) begin
      timeout_q <= `WDG_TIMEOUT_RST;
    end else if (timeout_wr) begin
      timeout_q <= timeout_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Elapsed count and safe state.

  // Expiry is a level: it is true while enabled, not yet safe and the count sits at or past the limit,
  // so lowering the timeout below the count expires on the next edge.
  wire expire = wdg_enable && !safe_active && (elapsed_q >= timeout_q);

  // Elapsed ticks; a disabled watchdog keeps zero. Count saturates at all ones.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      elapsed_q <= `ZERO16;
    end else if (!wdg_enable || query_valid) begin
      elapsed_q <= `ZERO16;
    end else if (tick && elapsed_q != `WDG_ELAPSED_MAX) begin
      elapsed_q <= elapsed_q + 16'h0001;
    end
  end

  // Safe state is sticky; a query does not clear it, only an explicit resume.
  // Expiry wins over a resume in the same cycle so the timeout is never lost.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      safe_active <= 1'b0;
    end else if (expire) begin
      safe_active <= 1'b1;
    end else if (resume) begin
      safe_active <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output forcing.

  // Digital safe value for one module's mode, given the last driven value.
  function dsafe;
    input [1:0] mode;
    input       last;
    begin
      case (mode)
        `DSAFE_OFF: dsafe = 1'b0;
        `DSAFE_ON:  dsafe = 1'b1;
        default:    dsafe = last;
      endcase
    end
  endfunction

  // Analog safe value for one channel.
  function [15:0] asafe;
    input [1:0]  mode;
    input [15:0] last;
    input [15:0] sv;
    input [15:0] lo;
    input [15:0] hi;
    begin
      case (mode)
        `ASAFE_VALUE: asafe = sv;
        `ASAFE_LOW:   asafe = lo;
        `ASAFE_HIGH:  asafe = hi;
        default:      asafe = last;
      endcase
    end
  endfunction

  // Safe values are worked out for every channel all the time, so that the
  // output registers below pick between two ready words in one place.
  wire [15:0] do_safe_bits;   // Safe value of each digital channel.
  wire [31:0] ao_safe_words;  // Safe value of each analog channel.

  // Digital channels: four per module, one shared mode per module.
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_do
      assign do_safe_bits[i] = dsafe(do_safe_mode[2*(i/4)+:2], do_out[i]);
    end
    // Analog channels, each with its own mode.
    for (i = 0; i < 2; i = i + 1) begin : g_ao
      assign ao_safe_words[16*i+:16] = asafe(ao_safe_mode[2*i+:2], ao_out[16*i+:16],
                                             ao_safe_val[16*i+:16], ao_low_lim[16*i+:16],
                                             ao_high_lim[16*i+:16]);
    end
  endgenerate

  // Outputs take their safe values on the expiry edge itself, not one cycle
  // later, and keep them while the safe state stands. A single process keeps
  // each output register with one driver.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      do_out <= `ZERO16;
      ao_out <= {`ZERO16, `ZERO16};
    end else if (safe_active || expire) begin
      // Hold mode feeds back the last driven value.
      do_out <= do_safe_bits;
      ao_out <= ao_safe_words;
    end else begin
      // Normal operation follows the host's values.
      do_out <= do_normal;
      ao_out <= ao_normal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channel address lookup, registered.

  wire [`MAP_ADDR_BITS-1:0] m_word;  // Combinational word address.
  wire [`MAP_ADDR_BITS-1:0] m_bit;   // Combinational coil address.
  wire [`MAP_ADDR_BITS-1:0] m_len;   // Combinational length.
  wire [3:0]                m_pos;   // Combinational bit position.
  wire                      m_hit;   // Combinational hit.

  channel_addr_map u_map (
    .slot_type  (slot_type),
    .slot_chans (slot_chans),
    .q_slot     (q_slot),
    .q_chan     (q_chan),
    .word_addr  (m_word),
    .bit_addr   (m_bit),
    .data_len   (m_len),
    .bit_pos    (m_pos),
    .hit        (m_hit)
  );

  // One cycle of latency keeps the data outputs on flip-flops.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      word_addr_q <= `ZERO16;
      bit_addr_q  <= `ZERO16;
      data_len_q  <= `ZERO16;
      bit_pos_q   <= 4'h0;
      hit_q       <= 1'b0;
    end else begin
      word_addr_q <= m_word;
      bit_addr_q  <= m_bit;
      data_len_q  <= m_len;
      bit_pos_q   <= m_pos;
      hit_q       <= m_hit;
    end
  end

endmodule
`default_nettype wire

// >>> verilog/host_link_watchdog_regs.vh
// Constants for the host link watchdog and channel address mapper.
`ifndef HOST_LINK_WATCHDOG_REGS_VH
`define HOST_LINK_WATCHDOG_REGS_VH

// Clock rate in kHz and watchdog tick period in ms.
`define WDG_CLK_KHZ        100000
`define WDG_TICK_MS        100
// Cycles per 100 ms tick, derived from the figures above.
`define WDG_TICK_CYCLES    (`WDG_TICK_MS * `WDG_CLK_KHZ)
// Last prescaler count of a tick: the cycle count above less one, at prescaler width.
`define WDG_TICK_LAST      24'h98967F
// Saturation limit of the elapsed tick count.
`define WDG_ELAPSED_MAX    16'hFFFF
// Timeout reset value: 50 ticks of 100 ms.
`define WDG_TIMEOUT_RST    16'h0032
// Slot count and widths of the map.
`define MAP_SLOTS          8
`define MAP_SLOT_BITS      3
`define MAP_CH_BITS        4
`define MAP_ADDR_BITS      16
// Module type codes.
`define MTYPE_NONE         2'h0
`define MTYPE_WORD         2'h1
`define MTYPE_BIT          2'h2
// Digital safe modes.
`define DSAFE_HOLD         2'h0
`define DSAFE_OFF          2'h1
`define DSAFE_ON           2'h2
// Analog safe modes.
`define ASAFE_HOLD         2'h0
`define ASAFE_VALUE        2'h1
`define ASAFE_LOW          2'h2
`define ASAFE_HIGH         2'h3
// Data lengths.
`define LEN_WORD           16'h0010
`define LEN_BIT            16'h0001
`define ZERO16             16'h0000

`endif

// >>> verilog/channel_addr_map.v
// Slot and channel to word and bit address mapper.
`timescale 1ns/1ps
`default_nettype none
`include "host_link_watchdog_regs.vh"

module channel_addr_map (
  input  wire [2*`MAP_SLOTS-1:0]            slot_type,  // Type of each slot, 2 bits per slot.
  input  wire [`MAP_CH_BITS*`MAP_SLOTS-1:0] slot_chans, // Channel count minus one per slot.
  input  wire [`MAP_SLOT_BITS-1:0]          q_slot,     // Slot to look up.
  input  wire [`MAP_CH_BITS-1:0]            q_chan,     // Channel within slot.
  output reg  [`MAP_ADDR_BITS-1:0]          word_addr,  // Register address.
  output reg  [`MAP_ADDR_BITS-1:0]          bit_addr,   // Coil address.
  output reg  [`MAP_ADDR_BITS-1:0]          data_len,   // Length in bits.
  output reg  [3:0]                         bit_pos,    // Bit inside the word.
  output reg                                hit         // Channel exists.
);

  // Words one slot takes: one per channel, or one shared word for bit modules.
  function [`MAP_ADDR_BITS-1:0] slot_words;
    input [1:0]               t;
    input [`MAP_CH_BITS-1:0]  n;
    begin
      if (t == `MTYPE_WORD) begin
        slot_words = {{(`MAP_ADDR_BITS-`MAP_CH_BITS){1'b0}}, n} + 16'h0001;
      end else if (t == `MTYPE_BIT) begin
        slot_words = 16'h0001;
      end else begin
        slot_words = `ZERO16;
      end
    end
  endfunction

  // Running base per slot, built in slot order.
  wire [`MAP_ADDR_BITS-1:0] base [0:`MAP_SLOTS];
  assign base[0] = `ZERO16;
  genvar g;
  generate
    for (g = 0; g < `MAP_SLOTS; g = g + 1) begin : g_base
      assign base[g+1] = base[g] + slot_words(slot_type[2*g+:2],
                                               slot_chans[`MAP_CH_BITS*g+:`MAP_CH_BITS]);
    end
  endgenerate

  // Lookup of one channel; the map depends only on the modules, not the host link.
  always @* begin
    word_addr = `ZERO16;
    bit_addr  = `ZERO16;
    data_len  = `ZERO16;
    bit_pos   = 4'h0;
    hit       = 1'b0;
    case (slot_type[2*q_slot+:2])
      `MTYPE_WORD: begin
        // Consecutive words, bit address is word times sixteen.
        hit       = (q_chan <= slot_chans[`MAP_CH_BITS*q_slot+:`MAP_CH_BITS]);
        word_addr = base[q_slot] + {{(`MAP_ADDR_BITS-`MAP_CH_BITS){1'b0}}, q_chan};
        bit_addr  = {word_addr[11:0], 4'h0};
        data_len  = `LEN_WORD;
      end
      `MTYPE_BIT: begin
        // Shared word, bit position equals the channel number.
        hit       = (q_chan <= slot_chans[`MAP_CH_BITS*q_slot+:`MAP_CH_BITS]);
        word_addr = base[q_slot];
        bit_pos   = q_chan;
        bit_addr  = {word_addr[11:0], q_chan};
        data_len  = `LEN_BIT;
      end
      default: begin
        // Empty slot maps nothing.
        hit = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// >>> test/host_link_watchdog_monitor.sv
// Checker for the host link watchdog ports.
`timescale 1ns/1ps
`default_nettype none
module host_link_watchdog_monitor (
  input wire        clk,
  input wire        reset,
  input wire        wdg_enable,
  input wire        query_valid,
  input wire        cfg_reset,
  input wire        timeout_wr,
  input wire        resume,
  input wire [31:0] do_safe_mode,
  input wire [15:0] do_out,
  input wire        safe_active,
  input wire [15:0] timeout_q,
  input wire [15:0] elapsed_q,
  input wire [15:0] word_addr_q,
  input wire [15:0] bit_addr_q,
  input wire [15:0] data_len_q,
  input wire [3:0]  bit_pos_q,
  input wire        hit_q
);
  // Expiry condition as the counter sees it; while safe, a resume still clears the state.
  wire due = wdg_enable && (elapsed_q >= timeout_q);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  AST_OFF: assert property (!wdg_enable |=> elapsed_q == 16'h0000)
    else $error("elapsed count moved while off");
  AST_EXP: assert property (due && !safe_active |=> safe_active)
    else $error("expiry did not force safe state");
  AST_HOLD: assert property (safe_active && !resume |=> safe_active)
    else $error("safe state left without resume");
  AST_RES: assert property (safe_active && resume && !due |=> !safe_active)
    else $error("resume did not leave safe state");
  AST_CFG: assert property (cfg_reset && !timeout_wr |=> timeout_q == 16'h0032)
    else $error("default timeout not restored");
  AST_QRY: assert property (query_valid && wdg_enable |=> elapsed_q == 16'h0000)
    else $error("query did not restart count");
  // Only the off and on settings are checked; hold depends on history.
  AST_DO: assert property (safe_active && $past(safe_active) &&
    $past(do_safe_mode[1:0]) inside {2'h1, 2'h2} |->
    do_out[3:0] == {4{$past(do_safe_mode[1])}})
    else $error("first module safe value wrong");
  AST_WMAP: assert property (hit_q && data_len_q == 16'h0010 |->
    bit_addr_q == {word_addr_q[11:0], 4'h0})
    else $error("word channel coil address wrong");
  AST_BMAP: assert property (hit_q && data_len_q == 16'h0001 |->
    bit_addr_q == {word_addr_q[11:0], bit_pos_q})
    else $error("bit channel coil address wrong");
  // Main scenarios: entering and leaving safe state, a packed bit hit.
  cover property ($rose(safe_active));
  cover property ($fell(safe_active));
  cover property (hit_q && data_len_q == 16'h0001);
endmodule
bind host_link_watchdog host_link_watchdog_monitor mon (
  .clk          (clk),
  .reset        (reset),
  .wdg_enable   (wdg_enable),
  .query_valid  (query_valid),
  .cfg_reset    (cfg_reset),
  .timeout_wr   (timeout_wr),
  .resume       (resume),
  .do_safe_mode (do_safe_mode),
  .do_out       (do_out),
  .safe_active  (safe_active),
  .timeout_q    (timeout_q),
  .elapsed_q    (elapsed_q),
  .word_addr_q  (word_addr_q),
  .bit_addr_q   (bit_addr_q),
  .data_len_q   (data_len_q),
  .bit_pos_q    (bit_pos_q),
  .hit_q        (hit_q)
);
`default_nettype wire

// >>> test/host_model.sv
// Host side model that polls the device with queries.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire clk,
  input  wire poll,
  output reg  query_valid
);
  reg [1:0] gap_q; // Free-running cycle count modulo four; a query goes out when it reads 3.
  initial begin
    query_valid = 1'b0;
    gap_q = 2'h0;
  end
  // One-cycle query every fourth cycle while the host polls.
  always @(posedge clk) begin
    gap_q <= #1 gap_q + 2'h1;
    query_valid <= #1 poll && (gap_q == 2'h3);
  end
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the host link watchdog.
`timescale 1ns/1ps
`default_nettype none
`include "host_link_watchdog_regs.vh"
module testbench;
  reg         clk, reset, wdg_enable, poll, cfg_reset, timeout_wr, resume;
  reg  [15:0] timeout_in, do_normal, slot_type, exp_do;
  reg  [31:0] do_safe_mode, ao_normal, ao_safe_val, ao_low_lim, ao_high_lim;
  reg  [31:0] slot_chans, exp_ao;
  reg  [3:0]  ao_safe_mode, q_chan;
  reg  [2:0]  q_slot;
  wire        query_valid, safe_active, hit_q;
  wire [15:0] do_out, timeout_q, elapsed_q, word_addr_q, bit_addr_q, data_len_q;
  wire [31:0] ao_out;
  wire [3:0]  bit_pos_q;
  integer     fails, tests_run, seed, s, c, k, t, base;
  host_link_watchdog uut (
    .clk          (clk),
    .reset        (reset),
    .wdg_enable   (wdg_enable),
    .query_valid  (query_valid),
    .cfg_reset    (cfg_reset),
    .timeout_wr   (timeout_wr),
    .timeout_in   (timeout_in),
    .resume       (resume),
    .do_normal    (do_normal),
    .do_safe_mode (do_safe_mode),
    .ao_normal    (ao_normal),
    .ao_safe_mode (ao_safe_mode),
    .ao_safe_val  (ao_safe_val),
    .ao_low_lim   (ao_low_lim),
    .ao_high_lim  (ao_high_lim),
    .slot_type    (slot_type),
    .slot_chans   (slot_chans),
    .q_slot       (q_slot),
    .q_chan       (q_chan),
    .do_out       (do_out),
    .ao_out       (ao_out),
    .safe_active  (safe_active),
    .timeout_q    (timeout_q),
    .elapsed_q    (elapsed_q),
    .word_addr_q  (word_addr_q),
    .bit_addr_q   (bit_addr_q),
    .data_len_q   (data_len_q),
    .bit_pos_q    (bit_pos_q),
    .hit_q        (hit_q)
  );
  host_model host (.clk(clk), .poll(poll), .query_valid(query_valid));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("[ERR] %0s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Waits n edges, then lands just after the last one.
  task step(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr_timeout(input logic [15:0] v);
    timeout_in = v;
    timeout_wr = 1'b1;
    step(1);
    timeout_wr = 1'b0;
  endtask
  // Safe values per module; hold expects the last normal value.
  task chk_safe;
    for (k = 0; k < 4; k = k + 1)
      case (do_safe_mode[2*k+:2])
        `DSAFE_OFF: exp_do[4*k+:4] = 4'h0;
        `DSAFE_ON: exp_do[4*k+:4] = 4'hF;
        default: exp_do[4*k+:4] = do_normal[4*k+:4];
      endcase
    for (k = 0; k < 2; k = k + 1)
      case (ao_safe_mode[2*k+:2])
        `ASAFE_VALUE: exp_ao[16*k+:16] = ao_safe_val[16*k+:16];
        `ASAFE_LOW: exp_ao[16*k+:16] = ao_low_lim[16*k+:16];
        `ASAFE_HIGH: exp_ao[16*k+:16] = ao_high_lim[16*k+:16];
        default: exp_ao[16*k+:16] = ao_normal[16*k+:16];
      endcase
    chk("do_out", do_out, exp_do);
    chk("ao_out", ao_out, exp_ao);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // A hung handshake must not stall the run forever.
  initial begin
    #200000;
    fails = fails + 1;
    wrap_up;
  end
  initial begin
    seed = 32'hEA011980;
    fails = 0;
    tests_run = 0;
    {reset, wdg_enable, poll, cfg_reset, timeout_wr, resume} = 6'h20;
    {timeout_in, q_slot, q_chan, slot_type} = 39'h0;
    {do_normal, do_safe_mode, ao_safe_mode} = 52'h0;
    ao_normal = $random(seed);
    ao_safe_val = $random(seed);
    ao_low_lim = $random(seed);
    ao_high_lim = $random(seed);
    slot_chans = $random(seed);
    step(4);
    reset = 1'b0;
    chk("timeout", timeout_q, 16'h0032);
    // Switched off, even a zero timeout never expires.
    wr_timeout(16'h0000);
    step(20);
    chk("safe", safe_active, 1'b0);
    for (s = 0; s < 6; s = s + 1) begin
      do_normal = $random(seed);
      ao_normal = $random(seed);
      do_safe_mode = $random(seed);
      ao_safe_mode = do_safe_mode[13:10];
      step(2);
      chk("do_norm", do_out, do_normal);
      wdg_enable = 1'b1;
      poll = 1'b1;
      step(3);
      chk("safe", safe_active, 1'b1);
      chk_safe;
      // Queries alone never release the safe state.
      step(8);
      chk("safe", safe_active, 1'b1);
      wr_timeout(16'h0040);
      resume = 1'b1;
      step(1);
      resume = 1'b0;
      step(2);
      chk("safe", safe_active, 1'b0);
      chk("ao_norm", ao_out, ao_normal);
      chk("do_norm", do_out, do_normal);
      chk("timeout", timeout_q, 16'h0040);
      wdg_enable = 1'b0;
      poll = 1'b0;
      wr_timeout(16'h0000);
    end
    cfg_reset = 1'b1;
    step(1);
    cfg_reset = 1'b0;
    chk("timeout", timeout_q, 16'h0032);
    // Address map against an integer model over random slot layouts.
    for (s = 0; s < 12; s = s + 1) begin
      slot_chans = $random(seed);
      for (k = 0; k < 8; k = k + 1) begin
        t = $unsigned($random(seed)) % 3;
        slot_type[2*k+:2] = t[1:0];
      end
      base = 0;
      for (k = 0; k < 8; k = k + 1) begin
        t = slot_type[2*k+:2];
        for (c = 0; c < 16; c = c + 1) begin
          q_slot = k[2:0];
          q_chan = c[3:0];
          step(2);
          chk("hit", hit_q, t != 0 && c <= slot_chans[4*k+:4]);
          if (t == 1 && c <= slot_chans[4*k+:4]) begin
            chk("word", word_addr_q, base + c);
            chk("bit", bit_addr_q, (base + c) * 16);
            chk("len", data_len_q, 16'h0010);
          end else if (t == 2 && c <= slot_chans[4*k+:4]) begin
            chk("word", word_addr_q, base);
            chk("len", data_len_q, 16'h0001);
            chk("bit", bit_addr_q, base * 16 + c);
            chk("pos", bit_pos_q, c);
          end
        end
        if (t == 1)
          base = base + slot_chans[4*k+:4] + 1;
        else if (t == 2)
          base = base + 1;
      end
    end
    wrap_up;
  end
endmodule
`default_nettype wire
